// *** common/erd_pkg.sv ***
package erd_pkg;

    // ---------------------------------------------------------------
    // Register map (byte addresses on the register bus).
    // ---------------------------------------------------------------
    localparam logic [4:0]  OFS_CTRL      = 5'h00;
    localparam logic [4:0]  OFS_LIST_BASE = 5'h04;
    localparam logic [4:0]  OFS_STATUS    = 5'h08;
    localparam logic [4:0]  OFS_MASK      = 5'h0C;
    localparam logic [4:0]  OFS_CUR_DESC  = 5'h10;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // Control and status field positions.
    localparam int CTRL_CSUM_EN_BIT = 0;
    localparam int ST_RX_IRQ_BIT    = 0;
    localparam int ST_TS_DROP_BIT   = 1;
    localparam int ST_WRAP_BIT      = 2;
    localparam int ST_WIDTH         = 3;

    // Reset values.
    localparam logic [31:0]         LIST_BASE_RST = 32'h0000_0000;
    localparam logic [ST_WIDTH-1:0] MASK_RST      = 3'h0;

    // Descriptor word 1 fields.
    localparam int W1_SUPPRESS_BIT = 31;
    localparam int W1_RING_END_BIT = 15;
    localparam int W1_CHAINED_BIT  = 14;
    localparam int W1_BS1_MSB      = 12;

    // Extended status word 4 fields.
    localparam int W4_TS_DROP_BIT  = 14;
    localparam int W4_PTP_V2_BIT   = 13;
    localparam int W4_PTP_ETH_BIT  = 12;
    localparam int W4_MTYPE_LSB    = 8;
    localparam int W4_IPV6_BIT     = 7;
    localparam int W4_IPV4_BIT     = 6;

    // A descriptor spans eight words, so sequential walking steps 32 bytes.
    localparam logic [31:0] DESC_STRIDE = 32'h0000_0020;

    // Descriptor as fetched from memory.
    typedef struct packed {
        logic [31:0] addr;    // Where this descriptor sits.
        logic [31:0] word1;   // Control word.
        logic [31:0] word2;   // First buffer pointer.
        logic [31:0] word3;   // Second buffer or next descriptor pointer.
    } erd_desc_t;

    // Per-frame facts from the receive path at end of frame.
    typedef struct packed {
        logic       ts_captured;  // A timestamp was taken.
        logic       fifo_overflow;// The receive FIFO overflowed.
        logic       ptp_v2;       // Version 2 message format.
        logic       ptp_over_eth; // Carried directly in Ethernet.
        logic [3:0] msg_type;     // PTP message type.
        logic       is_ipv6;      // IPv6 packet.
        logic       is_ipv4;      // IPv4 packet.
    } erd_frame_t;

endpackage : erd_pkg

// *** src/erd_rx_desc.sv ***
`timescale 1ns/1ps
module erd_rx_desc (
    input  wire logic               clock,        // 100 MHz system clock.
    input  wire logic               nrst,         // Asynchronous reset, active low.
    input  wire logic [4:0]         avs_address,  // Byte address.
    input  wire logic               avs_read,     // Read request.
    input  wire logic               avs_write,    // Write request.
    input  wire logic [31:0]        avs_writedata,// Write data.
    input  wire logic [3:0]         avs_byteenable,// Byte lanes.
    output logic [31:0]             avs_readdata, // Read data.
    output logic                    avs_waitrequest,// Stall.
    input  wire logic               desc_valid,   // Fetched descriptor present, one cycle.
    input  wire erd_pkg::erd_desc_t desc_in,      // Fetched descriptor.
    output logic                    plan_valid_q, // Decoded plan pulse.
    output logic [31:0]             buf1_addr_q,  // First buffer address.
    output logic [12:0]             buf1_size_q,  // First buffer size in bytes.
    output logic                    buf1_skip_q,  // First buffer is skipped.
    output logic [31:0]             buf2_addr_q,  // Second buffer address.
    output logic                    buf2_used_q,  // Second buffer is a buffer.
    output logic [31:0]             next_desc_q,  // Next descriptor address.
    input  wire logic               frame_end,    // Frame ended in current descriptor.
    input  wire erd_pkg::erd_frame_t frame_in,    // Facts for that frame.
    output logic                    wb_valid_q,   // Word 4 write-back pulse.
    output logic [31:0]             wb_word4_q,   // Extended status word.
    output logic                    irq_q         // Level interrupt.
);

    // ---------------------------------------------------------------
    // Register bus slave.
    // ---------------------------------------------------------------
    logic                        csum_en_q;
    logic [31:0]                 list_base_q;
    logic [erd_pkg::ST_WIDTH-1:0] status_q;
    logic [erd_pkg::ST_WIDTH-1:0] mask_q;
    logic [31:0]                 cur_desc_q;
    logic                        suppress_q;
    logic                        wait_q;
    logic                        req;
    logic                        wr_take;
    logic [31:0]                 rd_mux;

    assign req     = avs_read | avs_write;
    assign wr_take = avs_write & ~wait_q;

    // Read mux; unmapped addresses read as zero.
    always_comb begin
        case (avs_address)
            erd_pkg::OFS_CTRL:      rd_mux = {31'h0000_0000, csum_en_q};
            erd_pkg::OFS_LIST_BASE: rd_mux = list_base_q;
            erd_pkg::OFS_STATUS:    rd_mux = {29'h0000_0000, status_q};
            erd_pkg::OFS_MASK:      rd_mux = {29'h0000_0000, mask_q};
            erd_pkg::OFS_CUR_DESC:  rd_mux = cur_desc_q;
            default:                rd_mux = erd_pkg::UNMAPPED_READ;
        endcase
    end

    // Every access stalls exactly one cycle, so the data path is registered.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wait_q       <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if (!wait_q) begin
            wait_q <= 1'b1;
        end else if (req) begin
            wait_q       <= 1'b0;
            avs_readdata <= rd_mux;
        end
    end

    assign avs_waitrequest = wait_q;

    // Configuration registers, written at the edge after the stall ends, while waitrequest is low.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            csum_en_q   <= 1'b0;
            list_base_q <= erd_pkg::LIST_BASE_RST;
            mask_q      <= erd_pkg::MASK_RST;
        end else if (wr_take) begin
            if (avs_byteenable[0]) begin
                case (avs_address)
                    erd_pkg::OFS_CTRL: csum_en_q <= avs_writedata[erd_pkg::CTRL_CSUM_EN_BIT];
                    erd_pkg::OFS_MASK: mask_q <= avs_writedata[erd_pkg::ST_WIDTH-1:0];
                    default:           ;
                endcase
            end
            if (avs_address == erd_pkg::OFS_LIST_BASE) begin
                for (int b = 0; b < 4; b++) begin
                    if (avs_byteenable[b]) list_base_q[8*b +: 8] <= avs_writedata[8*b +: 8];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Descriptor decode.
    // ---------------------------------------------------------------
    logic ring_end;
    logic chained;

    assign ring_end = desc_in.word1[erd_pkg::W1_RING_END_BIT];
    assign chained  = desc_in.word1[erd_pkg::W1_CHAINED_BIT];

    // Only the documented control fields are looked at; reserved bits are dropped.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            plan_valid_q <= 1'b0;
            buf1_addr_q  <= 32'h0000_0000;
            buf1_size_q  <= 13'h0000;
            buf1_skip_q  <= 1'b0;
            buf2_addr_q  <= 32'h0000_0000;
            buf2_used_q  <= 1'b0;
            next_desc_q  <= 32'h0000_0000;
            cur_desc_q   <= 32'h0000_0000;
            suppress_q   <= 1'b0;
        end else begin
            plan_valid_q <= desc_valid;
            if (desc_valid) begin
                cur_desc_q  <= desc_in.addr;
                suppress_q  <= desc_in.word1[erd_pkg::W1_SUPPRESS_BIT];
                buf1_addr_q <= desc_in.word2;
                buf1_size_q <= desc_in.word1[erd_pkg::W1_BS1_MSB:0];
                buf1_skip_q <= (desc_in.word1[erd_pkg::W1_BS1_MSB:0] == 13'h0000);
                // A size off a multiple of four is a software fault; not trimmed.
                buf2_addr_q <= chained ? 32'h0000_0000 : desc_in.word3;
                buf2_used_q <= ~chained;
                if (ring_end) begin
                    next_desc_q <= list_base_q;
                end else if (chained) begin
                    next_desc_q <= desc_in.word3;
                end else begin
                    next_desc_q <= desc_in.addr + erd_pkg::DESC_STRIDE;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Extended status write-back.
    // ---------------------------------------------------------------
    logic [31:0] word4;
    logic        ts_lost;

    assign ts_lost = frame_in.ts_captured & frame_in.fifo_overflow;

    // Reserved bits of the word are built as zero on purpose.
    always_comb begin
        word4 = 32'h0000_0000;
        word4[erd_pkg::W4_TS_DROP_BIT] = ts_lost;
        word4[erd_pkg::W4_PTP_V2_BIT]  = frame_in.ptp_v2;
        word4[erd_pkg::W4_PTP_ETH_BIT] = frame_in.ptp_over_eth;
        word4[erd_pkg::W4_MTYPE_LSB+3:erd_pkg::W4_MTYPE_LSB] = frame_in.msg_type;
        if (csum_en_q) begin
            word4[erd_pkg::W4_IPV6_BIT] = frame_in.is_ipv6;
            word4[erd_pkg::W4_IPV4_BIT] = frame_in.is_ipv4;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wb_valid_q <= 1'b0;
            wb_word4_q <= 32'h0000_0000;
        end else begin
            wb_valid_q <= frame_end;
            if (frame_end) begin
                wb_word4_q <= word4;
            end
        end
    end

    // ---------------------------------------------------------------
    // Interrupt status, mask and line.
    // ---------------------------------------------------------------
    logic [erd_pkg::ST_WIDTH-1:0] ev;
    logic [erd_pkg::ST_WIDTH-1:0] clr;

    always_comb begin
        ev = '0;
        ev[erd_pkg::ST_RX_IRQ_BIT]  = frame_end & ~suppress_q;
        ev[erd_pkg::ST_TS_DROP_BIT] = frame_end & ts_lost;
        ev[erd_pkg::ST_WRAP_BIT]    = desc_valid & ring_end;
        clr = '0;
        if (wr_take && avs_address == erd_pkg::OFS_STATUS && avs_byteenable[0]) begin
            clr = avs_writedata[erd_pkg::ST_WIDTH-1:0];
        end
    end

    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            status_q <= '0;
            irq_q    <= 1'b0;
        end else begin
            status_q <= (status_q & ~clr) | ev;
            irq_q    <= |(((status_q & ~clr) | ev) & mask_q);
        end
    end

    // ---------------------------------------------------------------
    // Checks.
    // ---------------------------------------------------------------
    property p_suppress;
        @(posedge clock) disable iff (!nrst)
        (frame_end && suppress_q && !status_q[erd_pkg::ST_RX_IRQ_BIT] && !clr[0])
            |=> !status_q[erd_pkg::ST_RX_IRQ_BIT];
    endproperty
    a_suppress: assert property (p_suppress) else $error("suppressed frame set rx flag");

    property p_rx_set;
        @(posedge clock) disable iff (!nrst)
        (frame_end && !suppress_q) |=> status_q[erd_pkg::ST_RX_IRQ_BIT];
    endproperty
    a_rx_set: assert property (p_rx_set) else $error("rx flag not set");

    property p_wrap;
        @(posedge clock) disable iff (!nrst)
        (desc_valid && ring_end) |=> (next_desc_q == $past(list_base_q));
    endproperty
    a_wrap: assert property (p_wrap) else $error("ring end did not wrap");

    property p_chain;
        @(posedge clock) disable iff (!nrst)
        (desc_valid && chained && !ring_end) |=> (next_desc_q == $past(desc_in.word3))
            && !buf2_used_q;
    endproperty
    a_chain: assert property (p_chain) else $error("chained pointer wrong");

    property p_skip;
        @(posedge clock) disable iff (!nrst)
        desc_valid |=> (buf1_skip_q == ($past(desc_in.word1[12:0]) == 13'h0000));
    endproperty
    a_skip: assert property (p_skip) else $error("skip flag mismatch");

    property p_buf1;
        @(posedge clock) disable iff (!nrst)
        desc_valid |=> plan_valid_q && (buf1_addr_q == $past(desc_in.word2));
    endproperty
    a_buf1: assert property (p_buf1) else $error("buffer address wrong");

    property p_tsdrop;
        @(posedge clock) disable iff (!nrst)
        frame_end |=> wb_valid_q && (wb_word4_q[erd_pkg::W4_TS_DROP_BIT]
            == $past(frame_in.ts_captured && frame_in.fifo_overflow));
    endproperty
    a_tsdrop: assert property (p_tsdrop) else $error("timestamp drop bit wrong");

    property p_ptp;
        @(posedge clock) disable iff (!nrst)
        frame_end |=> (wb_word4_q[erd_pkg::W4_PTP_V2_BIT] == $past(frame_in.ptp_v2))
            && (wb_word4_q[erd_pkg::W4_PTP_ETH_BIT] == $past(frame_in.ptp_over_eth));
    endproperty
    a_ptp: assert property (p_ptp) else $error("ptp bits wrong");

    property p_ipbits;
        @(posedge clock) disable iff (!nrst)
        (frame_end && !csum_en_q) |=> (wb_word4_q[7:6] == 2'h0);
    endproperty
    a_ipbits: assert property (p_ipbits) else $error("ip bits set while offload off");

    property p_reserved;
        @(posedge clock) disable iff (!nrst)
        wb_valid_q |-> (wb_word4_q[31:15] == 17'h00000) && (wb_word4_q[5:0] == 6'h00);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

endmodule : erd_rx_desc

// *** verif/erd_host_model.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host memory model: presents one descriptor per fetch request.
// ---------------------------------------------------------------
module erd_host_model (
    input  wire logic               clock,    // System clock.
    input  wire logic               nrst,     // Asynchronous reset, active low.
    input  wire logic               req,      // Fetch request from the bench.
    input  wire erd_pkg::erd_desc_t req_desc, // Descriptor as software built it.
    output logic                    valid_q,  // One-cycle descriptor strobe.
    output erd_pkg::erd_desc_t      desc_q    // Descriptor words on the fetch port.
);
    // Software keeps the first size a multiple of four; idle words toggle so that
    // a stale descriptor never looks like a fresh one.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            valid_q <= 1'b0;
            desc_q  <= '0;
        end else if (req) begin
            valid_q           <= 1'b1;
            desc_q            <= req_desc;
            desc_q.word1[1:0] <= 2'h0;
        end else begin
            valid_q <= 1'b0;
            desc_q  <= ~desc_q;
        end
    end
endmodule : erd_host_model

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    // ---------------------------------------------------------------
    // Stimulus and observation signals.
    // ---------------------------------------------------------------
    localparam logic [31:0] BASE = 32'h8000_1000;
    logic                clock, nrst, rd, wr, req, frame_end, dv, plan_v, wb_v, irq;
    logic                wait_r, skip, used;
    logic [4:0]          addr;
    logic [3:0]          be;
    logic [12:0]         buf1_s;
    logic [31:0]         wdata, rdata, buf1_a, buf2_a, next_d, word4;
    erd_pkg::erd_desc_t  req_d, desc;
    erd_pkg::erd_frame_t frame;
    int                  error_cnt = 0;
    int                  total_checks = 0;

    erd_rx_desc uut (
        .clock(clock), .nrst(nrst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(wait_r), .desc_valid(dv), .desc_in(desc), .plan_valid_q(plan_v),
        .buf1_addr_q(buf1_a), .buf1_size_q(buf1_s), .buf1_skip_q(skip),
        .buf2_addr_q(buf2_a), .buf2_used_q(used), .next_desc_q(next_d),
        .frame_end(frame_end), .frame_in(frame), .wb_valid_q(wb_v), .wb_word4_q(word4),
        .irq_q(irq));

    erd_host_model host (.clock(clock), .nrst(nrst), .req(req), .req_desc(req_d),
        .valid_q(dv), .desc_q(desc));

    // Free-running 100 MHz clock.
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic complete_run;
        if (error_cnt == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    task automatic hang(input string msg);
        error_cnt++;
        $display("unexpected at %0t: no answer from %s", $time, msg);
        complete_run();
    endtask : hang

    // One bus transfer; the request holds until waitrequest is seen low at an edge.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] b, output logic [31:0] q);
        int n;
        @(posedge clock);
        rd    <= !w;
        wr    <= w;
        addr  <= a;
        wdata <= d;
        be    <= b;
        for (n = 0; n < 20; n++) begin
            @(posedge clock);
            if (wait_r === 1'b0) break;
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n == 20) hang("bus");
    endtask : bus

    // Sampling one step after the edge avoids racing the registered pulses.
    task automatic wait_pulse(input logic frame_side);
        int n;
        for (n = 0; n < 10; n++) begin
            #1;
            if ((frame_side ? wb_v : plan_v) === 1'b1) break;
            @(posedge clock);
        end
        if (n == 10) hang("pulse");
    endtask : wait_pulse

    task automatic send_desc(input erd_pkg::erd_desc_t d);
        @(posedge clock);
        req   <= 1'b1;
        req_d <= d;
        @(posedge clock);
        req <= 1'b0;
        wait_pulse(1'b0);
    endtask : send_desc

    task automatic send_frame(input erd_pkg::erd_frame_t f);
        @(posedge clock);
        frame_end <= 1'b1;
        frame     <= f;
        @(posedge clock);
        frame_end <= 1'b0;
        wait_pulse(1'b1);
    endtask : send_frame

    task automatic reg_check;
        logic [31:0] q;
        bus(1'b0, erd_pkg::OFS_MASK, 32'h0, 4'hF, q);
        chk(q, 32'(erd_pkg::MASK_RST), "mask reset");
        bus(1'b0, 5'h14, 32'h0, 4'hF, q);
        chk(q, erd_pkg::UNMAPPED_READ, "unmapped read");
        bus(1'b1, erd_pkg::OFS_LIST_BASE, BASE, 4'hF, q);
        bus(1'b0, erd_pkg::OFS_LIST_BASE, 32'h0, 4'hF, q);
        chk(q, BASE, "list base");
    endtask : reg_check

    // Every ring-end and chained combination, then a zero first size.
    task automatic ring_walk;
        erd_pkg::erd_desc_t d;
        logic [31:0]        q;
        for (int i = 0; i < 5; i++) begin
            d.addr  = 32'h2000_0000 + 32'(i * 256);
            d.word1 = {16'hFFFE, i[0], i[1], 1'b1, (i == 4) ? 13'h0 : 13'(64 + i * 4)};
            d.word2 = 32'hA000_0001 + 32'(i);
            d.word3 = 32'hB000_0010 + 32'(i);
            send_desc(d);
            q = i[0] ? BASE : (i[1] ? d.word3 : d.addr + 32'h20);
            chk(next_d, q, "next descriptor");
            chk(buf1_a, d.word2, "first buffer");
            chk({skip, used, 17'h0, buf1_s}, {i == 4, !i[1], 17'h0, d.word1[12:0]}, "sizes");
            chk(buf2_a, i[1] ? 32'h0 : d.word3, "second buffer");
        end
        bus(1'b0, erd_pkg::OFS_STATUS, 32'h0, 4'hF, q);
        chk(q & 32'h4, 32'h4, "wrap status");
        bus(1'b0, erd_pkg::OFS_CUR_DESC, 32'h0, 4'hF, q);
        chk(q, 32'h2000_0400, "current descriptor");
    endtask : ring_walk

    // Word-four status with checksum offload off and then on.
    task automatic frame_status;
        erd_pkg::erd_frame_t fr[3];
        logic [31:0]         q;
        fr = '{10'b1111000110, 10'b1000111101, 10'b0110001110};
        for (int en = 0; en < 2; en++) begin
            bus(1'b1, erd_pkg::OFS_CTRL, 32'(en), 4'h1, q);
            foreach (fr[i]) begin
                send_frame(fr[i]);
                q = {17'h0, fr[i].ts_captured & fr[i].fifo_overflow, fr[i].ptp_v2,
                     fr[i].ptp_over_eth, fr[i].msg_type, fr[i].is_ipv6 & en[0],
                     fr[i].is_ipv4 & en[0], 6'h0};
                chk(word4, q, "word four");
            end
        end
        bus(1'b0, erd_pkg::OFS_STATUS, 32'h0, 4'hF, q);
        chk(q & 32'h2, 32'h2, "drop status");
    endtask : frame_status

    // Unmasked, masked off and suppressed frames; then a write-one clear.
    task automatic irq_path;
        erd_pkg::erd_desc_t d;
        logic [31:0]        q;
        d = {32'h3000_0000, 32'h0000_0040, 32'hA000_0000, 32'hB000_0000};
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, erd_pkg::OFS_MASK, (k == 1) ? 32'h0 : 32'h1, 4'h1, q);
            bus(1'b1, erd_pkg::OFS_STATUS, 32'h7, 4'h1, q);
            d.word1[31] = (k == 2);
            send_desc(d);
            send_frame('0);
            bus(1'b0, erd_pkg::OFS_STATUS, 32'h0, 4'hF, q);
            chk(q[0], k != 2, "receive flag");
            chk(irq, k == 0, "interrupt line");
        end
        bus(1'b1, erd_pkg::OFS_STATUS, 32'h7, 4'h1, q);
        bus(1'b0, erd_pkg::OFS_STATUS, 32'h0, 4'hF, q);
        chk({q[31:1], irq}, 32'h0, "status cleared");
    endtask : irq_path

    // Main sequence: reset for two cycles, then each scenario in turn.
    initial begin
        {rd, wr, req, frame_end, nrst} = '0;
        {addr, be, wdata} = '0;
        req_d = '0;
        frame = '0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        reg_check();
        ring_walk();
        frame_status();
        irq_path();
        complete_run();
    end
endmodule : tb_top
